//--- itm_cfg.svh
// constants of the interval timer channel: offsets, field positions, reset values
`ifndef ITM_CFG_SVH
`define ITM_CFG_SVH

// register offsets on the plain register port
`define ITM_OFS_COUNT 3'h0
`define ITM_OFS_CTRL 3'h1
`define ITM_OFS_GATE 3'h2
`define ITM_OFS_STATUS 3'h3
`define ITM_OFS_CE_LO 3'h4
`define ITM_OFS_CE_HI 3'h5

// gate port bit positions
`define ITM_GATE_BIT_T2 0
`define ITM_GATE_BIT_T3 6

// reset values
`define ITM_RST_GATE 8'h00
`define ITM_RST_COUNT 16'h0000
`define ITM_RST_CTRL 8'h34
`define ITM_RST_RDATA 8'h00

// counter constants
`define ITM_CE_ONE 16'h0001
`define ITM_CE_TWO 16'h0002
`define ITM_BCD_NINE 4'h9

`endif

//--- itm_pkg.sv
// types of the interval timer channel
package itm_pkg;

  // counting modes, as coded in the control word
  typedef enum logic [2:0] {
    ITM_MODE_TERM   = 3'b000,
    ITM_MODE_ONESHOT = 3'b001,
    ITM_MODE_RATE   = 3'b010,
    ITM_MODE_SQUARE = 3'b011,
    ITM_MODE_SWSTB  = 3'b100,
    ITM_MODE_HWSTB  = 3'b101
  } itm_mode_e;

  // byte access formats for the initial count
  typedef enum logic [1:0] {
    ITM_FMT_LATCH = 2'b00,
    ITM_FMT_LSB   = 2'b01,
    ITM_FMT_MSB   = 2'b10,
    ITM_FMT_BOTH  = 2'b11
  } itm_fmt_e;

  // control word layout
  typedef struct packed {
    logic [1:0] sel;
    itm_fmt_e   fmt;
    logic [2:0] mode;
    logic       bcd;
  } itm_ctrl_s;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } itm_req_s;

endpackage

//--- itm_timer.sv
// one 16-bit interval timer channel with rate, square, and strobe modes
`include "itm_cfg.svh"
module itm_timer (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire itm_pkg::itm_req_s i_req,
  output logic [7:0] o_rdata,
  input wire logic i_count_clock_in,
  output logic o_timer_out,
  output logic o_timer2_pin_out_n,
  output logic [1:0] o_gate_bits
);
  import itm_pkg::*;

  // decimal or binary decrement by one
  function automatic logic [15:0] itm_dec1(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - `ITM_CE_ONE;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (v[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = `ITM_BCD_NINE;
          end else begin
            r[4*i +: 4] = v[4*i +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // count clock pin synchroniser and edge detect
  logic cc_s1_q, cc_s2_q, cc_s3_q;
  logic cc_rise, cc_fall;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cc_s1_q <= 1'b0;
      cc_s2_q <= 1'b0;
      cc_s3_q <= 1'b0;
    end else begin
      cc_s1_q <= i_count_clock_in;
      cc_s2_q <= cc_s1_q;
      cc_s3_q <= cc_s2_q;
    end
  end

  assign cc_rise = cc_s2_q && !cc_s3_q;
  assign cc_fall = !cc_s2_q && cc_s3_q;

  // register port decode
  logic wr_count, wr_ctrl, wr_gate;
  assign wr_count = i_req.wr && (i_req.addr == `ITM_OFS_COUNT);
  assign wr_ctrl = i_req.wr && (i_req.addr == `ITM_OFS_CTRL)
                   && (i_req.wdata[5:4] != ITM_FMT_LATCH);
  assign wr_gate = i_req.wr && (i_req.addr == `ITM_OFS_GATE);

  // control word register
  itm_ctrl_s ctrl_q;
  logic [2:0] mode_w;
  assign mode_w = i_req.wdata[2] ? {1'b0, i_req.wdata[2:1]} : i_req.wdata[3:1];

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl_q <= `ITM_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= {i_req.wdata[7:4], mode_w, i_req.wdata[0]};
    end
  end

  // gate port, bits 0 and 6
  logic [7:0] gate_q;
  logic gate_rise, gate_fall;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      gate_q <= `ITM_RST_GATE;
    end else if (wr_gate) begin
      gate_q <= i_req.wdata & 8'h41;
    end
  end

  assign gate_rise = wr_gate && i_req.wdata[`ITM_GATE_BIT_T2] && !gate_q[`ITM_GATE_BIT_T2];
  assign gate_fall = wr_gate && !i_req.wdata[`ITM_GATE_BIT_T2] && gate_q[`ITM_GATE_BIT_T2];

  // trigger flip-flop and gate sampling on count clock rise
  logic trig_ff_q, trig_s_q, gate_s_q;

  always_ff @(posedge i_clk) begin
    if (!i_nrst || wr_ctrl) begin
      trig_ff_q <= 1'b0;
      trig_s_q <= 1'b0;
      gate_s_q <= 1'b0;
    end else begin
      if (gate_rise) begin
        trig_ff_q <= 1'b1;
      end else if (cc_rise) begin
        trig_ff_q <= 1'b0;
      end
      if (cc_rise) begin
        trig_s_q <= trig_ff_q;
        gate_s_q <= gate_q[`ITM_GATE_BIT_T2];
      end
    end
  end

  // count holding register and byte sequencing
  logic [15:0] cr_q;
  logic msb_next_q, valid_q, cnt_done;

  assign cnt_done = wr_count && ((ctrl_q.fmt != ITM_FMT_BOTH) || msb_next_q);

  always_ff @(posedge i_clk) begin
    if (!i_nrst || wr_ctrl) begin
      cr_q <= `ITM_RST_COUNT;
      msb_next_q <= 1'b0;
      valid_q <= 1'b0;
    end else if (wr_count) begin
      case (ctrl_q.fmt)
        ITM_FMT_LSB: begin
          cr_q[7:0] <= i_req.wdata;
        end
        ITM_FMT_MSB: begin
          cr_q[15:8] <= i_req.wdata;
        end
        ITM_FMT_BOTH: begin
          if (msb_next_q) begin
            cr_q[15:8] <= i_req.wdata;
          end else begin
            cr_q[7:0] <= i_req.wdata;
          end
          msb_next_q <= !msb_next_q;
        end
        default: begin
          cr_q <= cr_q;
        end
      endcase
      if (cnt_done) begin
        valid_q <= 1'b1;
      end
    end
  end

  // counting element state
  logic [15:0] ce_q, ce_d, nxt1, nxt2, half_load;
  logic out_q, out_d, pend_q, pend_d, armed_q, armed_d, extra_q, extra_d, run_q, run_d;
  logic trig_load, gated, is_strobe;

  assign nxt1 = itm_dec1(ce_q, ctrl_q.bcd);
  assign nxt2 = itm_dec1(nxt1, ctrl_q.bcd);
  assign half_load = {cr_q[15:1], 1'b0};
  assign trig_load = trig_s_q && valid_q;
  assign gated = (ctrl_q.mode == ITM_MODE_TERM) || (ctrl_q.mode == ITM_MODE_SWSTB);
  assign is_strobe = ctrl_q.mode[2];

  // next state of counter and output
  always_comb begin
    ce_d = ce_q;
    out_d = out_q;
    pend_d = pend_q;
    armed_d = armed_q;
    extra_d = extra_q;
    run_d = run_q;
    if (wr_ctrl) begin
      out_d = (mode_w != ITM_MODE_TERM);
      pend_d = 1'b0;
      armed_d = 1'b0;
      extra_d = 1'b0;
      run_d = 1'b0;
    end else begin
      if (cc_fall) begin
        case (ctrl_q.mode)
          ITM_MODE_RATE: begin
            if (pend_q || trig_load) begin
              ce_d = cr_q;
              out_d = 1'b1;
              run_d = 1'b1;
              pend_d = 1'b0;
            end else if (run_q && gate_s_q) begin
              if (ce_q == `ITM_CE_ONE) begin
                ce_d = cr_q;
                out_d = 1'b1;
              end else begin
                ce_d = nxt1;
                out_d = (nxt1 != `ITM_CE_ONE);
              end
            end
          end
          ITM_MODE_SQUARE: begin
            if (pend_q || trig_load) begin
              ce_d = half_load;
              out_d = 1'b1;
              extra_d = 1'b0;
              run_d = 1'b1;
              pend_d = 1'b0;
            end else if (run_q && gate_s_q) begin
              if (extra_q) begin
                extra_d = 1'b0;
                out_d = 1'b0;
                ce_d = half_load;
              end else if (ce_q == `ITM_CE_TWO) begin
                if (out_q && cr_q[0]) begin
                  extra_d = 1'b1;
                end else begin
                  out_d = !out_q;
                  ce_d = half_load;
                end
              end else begin
                ce_d = nxt2;
              end
            end
          end
          default: begin
            if ((gated && pend_q) || (!gated && trig_load)) begin
              ce_d = cr_q;
              armed_d = 1'b1;
              run_d = 1'b1;
              pend_d = 1'b0;
              if (is_strobe) begin
                out_d = 1'b1;
              end
            end else if (run_q && (gate_s_q || !gated)) begin
              ce_d = nxt1;
              if (is_strobe) begin
                out_d = !(armed_q && (ce_q == `ITM_CE_ONE));
                if (armed_q && (ce_q == `ITM_CE_ONE)) begin
                  armed_d = 1'b0;
                end
              end
            end
          end
        endcase
      end
      // in rate and square mode a gate fall forces output high without a count clock pulse
      if (gate_fall && !out_q && (ctrl_q.mode[2:1] == 2'b01)) begin
        out_d = 1'b1;
      end
      // a complete count write requests a load in terminal and software strobe mode, or in rate and square mode while stopped; set wins over the clear
      if (cnt_done) begin
        if (gated || (!ctrl_q.mode[2] && ctrl_q.mode[1] && !run_q)) begin
          pend_d = 1'b1;
        end
      end
    end
  end

  // counter and output flip-flops
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ce_q <= `ITM_RST_COUNT;
      out_q <= 1'b1;
      o_timer_out <= 1'b1;
      o_timer2_pin_out_n <= 1'b0;
      pend_q <= 1'b0;
      armed_q <= 1'b0;
      extra_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      ce_q <= ce_d;
      out_q <= out_d;
      o_timer_out <= out_d;
      o_timer2_pin_out_n <= !out_d;
      pend_q <= pend_d;
      armed_q <= armed_d;
      extra_q <= extra_d;
      run_q <= run_d;
    end
  end

  // gate bits shown on the port
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_gate_bits <= 2'b00;
    end else begin
      o_gate_bits <= {gate_q[`ITM_GATE_BIT_T3], gate_q[`ITM_GATE_BIT_T2]};
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= `ITM_RST_RDATA;
    end else if (i_req.rd) begin
      case (i_req.addr)
        `ITM_OFS_CTRL: begin
          o_rdata <= ctrl_q;
        end
        `ITM_OFS_GATE: begin
          o_rdata <= gate_q;
        end
        `ITM_OFS_STATUS: begin
          o_rdata <= {out_q, pend_q, run_q, armed_q, extra_q, ctrl_q.mode};
        end
        `ITM_OFS_CE_LO: begin
          o_rdata <= ce_q[7:0];
        end
        `ITM_OFS_CE_HI: begin
          o_rdata <= ce_q[15:8];
        end
        default: begin
          o_rdata <= `ITM_RST_RDATA;
        end
      endcase
    end else begin
      o_rdata <= `ITM_RST_RDATA;
    end
  end

endmodule

//--- itm_timer_properties.sv
// port assertions of the interval timer channel
`include "itm_cfg.svh"
module itm_timer_properties (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire itm_pkg::itm_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic i_count_clock_in,
  input wire logic o_timer_out,
  input wire logic o_timer2_pin_out_n,
  input wire logic [1:0] o_gate_bits
);
  import itm_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  logic [2:0] mode_q;
  logic [3:0] since_q;
  logic [4:0] low_q;
  logic ctrl_wr;
  logic gate_wr;
  // accepted control and gate writes
  assign ctrl_wr = i_req.wr && i_req.addr == `ITM_OFS_CTRL && i_req.wdata[5:4] != 2'b00;
  assign gate_wr = i_req.wr && i_req.addr == `ITM_OFS_GATE;
  // mode of the last control word
  always_ff @(posedge i_clk) begin
    if (!i_nrst) mode_q <= 3'h2;
    else if (ctrl_wr) mode_q <= i_req.wdata[3:1];
  end
  // cycles since the count clock pin fell
  always_ff @(posedge i_clk) begin
    if ($fell(i_count_clock_in)) since_q <= 4'h0;
    else if (since_q != 4'hf) since_q <= since_q + 4'h1;
  end
  // cycles the output has been low
  always_ff @(posedge i_clk) begin
    if (o_timer_out) low_q <= 5'h00;
    else if (low_q != 5'h1f) low_q <= low_q + 5'h01;
  end
  a_pin_inverse: assert property (o_timer2_pin_out_n == !o_timer_out)
    else $error("pin not inverse of output");
  a_rdata_idle: assert property (!$past(i_req.rd) |-> o_rdata == 8'h00)
    else $error("read data outside answer");
  a_gate_follow: assert property (gate_wr |-> ##2
    o_gate_bits == {$past(i_req.wdata[6], 2), $past(i_req.wdata[0], 2)})
    else $error("gate bits wrong");
  a_gate_reset: assert property ($rose(i_nrst) |-> o_gate_bits == 2'b00 && o_timer_out)
    else $error("reset state wrong");
  a_ctrl_out: assert property (ctrl_wr && i_req.wdata[3:2] != 2'b00 |-> ##[1:2] o_timer_out)
    else $error("output not set by control word");
  a_gate_fall: assert property (gate_wr && !i_req.wdata[0] && !o_timer_out && mode_q[1]
    |-> ##[1:2] o_timer_out)
    else $error("output not forced high");
  a_fall_timing: assert property ($fell(o_timer_out) |-> since_q inside {[1:8]})
    else $error("output fell off count clock fall");
  a_low_brief: assert property (mode_q[1:0] != 2'b11 && mode_q == $past(mode_q, 2)
    |-> low_q <= 5'd13)
    else $error("strobe too long");
  c_rate: cover property (mode_q == 3'h2 && $fell(o_timer_out));
  c_square: cover property (mode_q == 3'h3 && $fell(o_timer_out));
  c_gate: cover property (mode_q == 3'h5 && $fell(o_timer_out));
endmodule
bind itm_timer itm_timer_properties itm_timer_properties_i (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_req(i_req), .o_rdata(o_rdata), .i_count_clock_in(i_count_clock_in),
  .o_timer_out(o_timer_out), .o_timer2_pin_out_n(o_timer2_pin_out_n),
  .o_gate_bits(o_gate_bits));

//--- testbench.sv
// self-checking bench of the interval timer channel
`include "itm_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import itm_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_count_clock_in = 1'b0;
  itm_req_s i_req = '0;
  logic [7:0] o_rdata;
  logic [7:0] rv;
  logic o_timer_out;
  logic o_timer2_pin_out_n;
  logic [1:0] o_gate_bits;
  int err_count = 0;
  int checks = 0;
  int nfall = 0;
  int cyc = 0;
  int f;
  int g;
  itm_timer itm_timer_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .o_rdata(o_rdata),
    .i_count_clock_in(i_count_clock_in), .o_timer_out(o_timer_out),
    .o_timer2_pin_out_n(o_timer2_pin_out_n), .o_gate_bits(o_gate_bits));
  // system clock
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  // count clock of twelve cycles, fall counter, run limit
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc % 6 == 5) i_count_clock_in <= ~i_count_clock_in;
    if (cyc % 12 == 11) nfall <= nfall + 1;
    if (cyc == 30000) begin
      err_count++;
      print_verdict;
    end
  end
  task chk(string n, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wr(logic [2:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    i_req <= '0;
  endtask
  task rd(logic [2:0] a);
    @(posedge i_clk);
    i_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_req <= '0;
    #1 rv = o_rdata;
  endtask
  task cnt(logic [15:0] n);
    wr(`ITM_OFS_COUNT, n[7:0]);
    wr(`ITM_OFS_COUNT, n[15:8]);
  endtask
  // align just after a count clock fall
  task sync;
    int s;
    s = nfall;
    while (nfall == s) @(posedge i_clk);
    @(posedge i_clk);
    f = nfall;
  endtask
  task wait_out(logic lvl);
    int n;
    n = 0;
    while (o_timer_out !== lvl && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    g = nfall;
  endtask
  task gap(string n, logic lvl, int e);
    wait_out(lvl);
    chk(n, 16'(g - f), 16'(e));
  endtask
  task pulse;
    wr(`ITM_OFS_GATE, 8'h00);
    wr(`ITM_OFS_GATE, 8'h01);
  endtask
  task t_reset;
    chk("pin", 16'(o_timer2_pin_out_n), 16'h0000);
    chk("gates", 16'(o_gate_bits), 16'h0000);
    rd(3'h6);
    chk("unmapped", 16'(rv), 16'h0000);
    rd(`ITM_OFS_CTRL);
    chk("ctrl", 16'(rv), 16'(`ITM_RST_CTRL));
  endtask
  task t_rate;
    wr(`ITM_OFS_CTRL, 8'h34);
    wr(`ITM_OFS_GATE, 8'h41);
    repeat (3) @(posedge i_clk);
    chk("gates", 16'(o_gate_bits), 16'h0003);
    sync;
    cnt(16'h0003);
    gap("rate first", 1'b0, 3);
    gap("rate end", 1'b1, 4);
    gap("rate period", 1'b0, 6);
    wr(`ITM_OFS_GATE, 8'h00);
    repeat (3) @(posedge i_clk);
    chk("gate fall", 16'(o_timer_out), 16'h0001);
    sync;
    wr(`ITM_OFS_GATE, 8'h01);
    gap("trigger", 1'b0, 3);
    sync;
    cnt(16'h0005);
    gap("old count", 1'b0, 2);
    wait_out(1'b1);
    gap("new count", 1'b0, 7);
  endtask
  task t_square;
    wr(`ITM_OFS_CTRL, 8'h36);
    cnt(16'h0006);
    wait_out(1'b0);
    f = g;
    gap("even low", 1'b1, 3);
    wr(`ITM_OFS_CTRL, 8'h36);
    cnt(16'h0005);
    wait_out(1'b0);
    f = g;
    gap("odd low", 1'b1, 2);
    f = g;
    gap("odd high", 1'b0, 3);
  endtask
  task t_swstb;
    wr(`ITM_OFS_CTRL, 8'h38);
    sync;
    cnt(16'h0004);
    gap("strobe", 1'b0, 5);
    gap("strobe end", 1'b1, 6);
    repeat (2) sync;
    rd(`ITM_OFS_CE_HI);
    chk("wrap", 16'(rv), 16'h00ff);
    sync;
    wr(`ITM_OFS_COUNT, 8'h03);
    repeat (3) sync;
    wr(`ITM_OFS_COUNT, 8'h00);
    gap("second byte", 1'b0, 4);
  endtask
  task t_hwstb;
    wr(`ITM_OFS_GATE, 8'h00);
    wr(`ITM_OFS_CTRL, 8'h3a);
    cnt(16'h0003);
    repeat (5) sync;
    chk("idle", 16'(o_timer_out), 16'h0001);
    sync;
    pulse;
    gap("trigger", 1'b0, 4);
    sync;
    pulse;
    sync;
    pulse;
    gap("retrigger", 1'b0, 4);
  endtask
  task print_verdict;
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    t_reset;
    t_rate;
    t_square;
    t_swstb;
    t_hwstb;
    print_verdict;
  end
endmodule
